/* File: shared/mps_consts.svh */
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH
// clock rate of pclk
`define MPS_CLK_MHZ            250
// apb register byte offsets
`define MPS_CTRL_OFS           12'h000
`define MPS_STATUS_OFS         12'h004
// control register fields
`define MPS_CTRL_PSX_BIT       0
`define MPS_CTRL_DQS_BIT       1
`define MPS_CTRL_SRF_BIT       2
`define MPS_CTRL_ID_LSB        4
`define MPS_CTRL_FRM_LSB       12
// control register reset value
`define MPS_CTRL_RESET         32'h0000_0000
// self-refresh interval per row and bank pair
`define MPS_REFRESH_NS         7800
`define MPS_REFRESH_CYCLES     ((`MPS_REFRESH_NS * `MPS_CLK_MHZ) / 1000)
`endif

/* File: shared/mps_pkg.sv */
package mps_pkg;
    // power states, one-hot
    typedef enum logic [5:0] {
        S_DEEP_POWERDOWN = 6'h01,
        S_LIGHT_SLEEP    = 6'h02,
        S_STANDBY_IDLE   = 6'h04,
        S_ATTENTION      = 6'h08,
        S_ATTENTION_RD   = 6'h10,
        S_ATTENTION_WR   = 6'h20
    } mps_state_e;
    // wake pattern tracker
    typedef enum logic [2:0] {
        W_IDLE = 3'h1,
        W_FELL = 3'h2,
        W_SLOT = 3'h4
    } mps_wake_e;
endpackage : mps_pkg

/* File: hw/mps_power_ctrl.sv */
`include "mps_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mps_power_ctrl (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // decoded row packets, pclk domain
    input  wire logic        row_pkt_valid,
    input  wire logic        row_pkt_broadcast,
    input  wire logic        row_pkt_hit,
    input  wire logic        row_activate_cmd,
    input  wire logic        sleep_request_cmd,
    input  wire logic        conditional_sleep_cmd,
    input  wire logic        powerdown_request_cmd,
    input  wire logic        row_relax_cmd,
    input  wire logic [3:0]  row_bank,
    input  wire logic [8:0]  row_addr,
    // decoded column packets, pclk domain
    input  wire logic        col_pkt_valid,
    input  wire logic        col_read_cmd,
    input  wire logic        col_write_cmd,
    input  wire logic        relax_cmd,
    // serial request packet command
    input  wire logic        set_reset_cmd,
    // serial pins, asynchronous
    input  wire logic        serial_clock,
    input  wire logic        command_pin,
    input  wire logic        serial_io_pin,
    input  wire logic [5:0]  data_byte_a_pins,
    // state outputs
    output logic [5:0]       power_state,
    output logic             col_frame_ok,
    output logic             clock_sync_keep,
    output logic             self_refresh_on,
    output logic             self_refresh_tick,
    output logic [3:0]       refresh_bank,
    output logic [8:0]       refresh_row,
    output logic             bank_activate,
    output logic [3:0]       activate_bank,
    output logic [8:0]       activate_row
);
    // ************************************************************
    // constants
    // ************************************************************
    localparam logic [11:0] REF_CYC = 12'(`MPS_REFRESH_CYCLES);  // refresh spacing in pclk

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [8:0] sync1_q;                 // first stage, read by second only
    logic [8:0] sync2_q;                 // second stage
    logic       sck_prev_q;              // last serial clock level
    // two flip-flops per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // serial clock idles high, so no false edge after reset
            sync1_q    <= 9'h001;
            sync2_q    <= 9'h001;
            sck_prev_q <= 1'b1;
        end else begin
            sync1_q    <= {data_byte_a_pins, serial_io_pin, command_pin, serial_clock};
            sync2_q    <= sync1_q;
            sck_prev_q <= sync2_q[0];
        end
    end
    logic       sck_fall;                // serial clock falling edge seen
    logic       sck_rise;                // serial clock rising edge seen
    logic       cmd_s;                   // synced command pin
    logic       sio_s;                   // synced serial input
    logic [5:0] dqa_s;                   // synced wake address
    assign sck_fall = sck_prev_q & ~sync2_q[0];
    assign sck_rise = ~sck_prev_q & sync2_q[0];
    assign cmd_s    = sync2_q[1];
    assign sio_s    = sync2_q[2];
    assign dqa_s    = sync2_q[8:3];

    // ************************************************************
    // apb registers
    // ************************************************************
    logic [31:0] ctrl_q, ctrl_d;         // control register
    logic [31:0] prdata_q, prdata_d;     // read data
    logic        pready_q, pready_d;     // access ready
    logic        pslverr_q, pslverr_d;   // unmapped access
    mps_pkg::mps_state_e state_q, state_d;
    logic        exit_attention_active_q, exit_attention_active_d;
    logic        flag_q, flag_d;
    logic        selective_exit_bit, dqs, srf;
    logic [5:0]  dev_id;
    logic [3:0]  frm_ivl;
    assign selective_exit_bit     = ctrl_q[`MPS_CTRL_PSX_BIT];
    assign dqs     = ctrl_q[`MPS_CTRL_DQS_BIT];
    assign srf     = ctrl_q[`MPS_CTRL_SRF_BIT];
    assign dev_id  = ctrl_q[`MPS_CTRL_ID_LSB +: 6];
    assign frm_ivl = ctrl_q[`MPS_CTRL_FRM_LSB +: 4];
    // decode in setup phase, answer in access phase
    always_comb begin
        ctrl_d    = ctrl_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            pready_d = 1'b1;
            prdata_d = 32'h0000_0000;
            case (paddr)
                `MPS_CTRL_OFS:   prdata_d = ctrl_q & 32'h0000_F3F7;
                `MPS_STATUS_OFS: prdata_d = {24'h000000, exit_attention_active_q, self_refresh_on, state_q};
                default:         pslverr_d = 1'b1;
            endcase
        end else if (psel && penable && pready_q && pwrite && paddr == `MPS_CTRL_OFS) begin
            ctrl_d = pwdata & 32'h0000_F3F7;
        end
    end
    // register the bus side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `MPS_CTRL_RESET;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ************************************************************
    // wake pattern detector
    // ************************************************************
    mps_pkg::mps_wake_e wake_q, wake_d;
    logic wsio_q, wsio_d;                // serial input at falling edge
    logic wake_hit;                      // address matched, or selective exit set, this cycle
    logic low_power;                     // in light sleep or powerdown
    assign low_power = (state_q == mps_pkg::S_DEEP_POWERDOWN) || (state_q == mps_pkg::S_LIGHT_SLEEP);
    // tracks cmd 01 over fall then rise, then the address slot
    always_comb begin
        wake_d   = wake_q;
        wsio_d   = wsio_q;
        wake_hit = 1'b0;
        case (wake_q)
            mps_pkg::W_IDLE: begin
                if (low_power && sck_fall && !cmd_s) begin
                    wake_d = mps_pkg::W_FELL;
                    wsio_d = sio_s;
                end
            end
            mps_pkg::W_FELL: begin
                if (!low_power) begin
                    wake_d = mps_pkg::W_IDLE;
                end else if (sck_rise) begin
                    wake_d = mps_pkg::W_IDLE;
                    if (cmd_s) begin
                        if (selective_exit_bit) begin
                            wake_hit = 1'b1;
                        end else if (!dqs) begin
                            wake_hit = (dqa_s == dev_id);
                        end else begin
                            wake_d = mps_pkg::W_SLOT;
                        end
                    end
                end
            end
            mps_pkg::W_SLOT: begin
                if (!low_power) begin
                    wake_d = mps_pkg::W_IDLE;
                end else if (sck_rise) begin
                    wake_d   = mps_pkg::W_IDLE;
                    wake_hit = (dqa_s == dev_id);
                end
            end
            default: wake_d = mps_pkg::W_IDLE;
        endcase
    end
    logic exit_ok;                       // wake pattern hit and kind agrees
    // serial input 0 for sleep, 1 for powerdown
    assign exit_ok = wake_hit && (wsio_q == (state_q == mps_pkg::S_DEEP_POWERDOWN));

    // ************************************************************
    // power state machine
    // ************************************************************
    logic row_me, row_new, attention_active_grp, rel_any, sleep_go, pdn_go;
    logic [3:0] frm_q, frm_d;            // framing countdown
    logic ok_q, ok_d;                    // column framing allowed
    logic act_q, act_d;                  // activate strobe
    logic [3:0] abank_q, abank_d;
    logic [8:0] arow_q, arow_d;
    assign row_me   = row_pkt_valid && row_pkt_hit && !row_pkt_broadcast;
    assign attention_active_grp = (state_q == mps_pkg::S_ATTENTION) || (state_q == mps_pkg::S_ATTENTION_RD) ||
                      (state_q == mps_pkg::S_ATTENTION_WR);
    assign sleep_go = row_me && (sleep_request_cmd || (conditional_sleep_cmd && flag_q));
    assign pdn_go   = row_me && powerdown_request_cmd;
    assign rel_any  = (row_me && row_relax_cmd) || (col_pkt_valid && ok_q && relax_cmd);
    assign row_new  = row_me && !sleep_request_cmd && !conditional_sleep_cmd && !powerdown_request_cmd;
    // next state, exit target, flag, framing and activate
    always_comb begin
        state_d     = state_q;
        exit_attention_active_d = exit_attention_active_q;
        flag_d      = flag_q;
        frm_d       = (frm_q != 4'h0) ? frm_q - 4'h1 : 4'h0;
        act_d       = 1'b0;
        abank_d     = abank_q;
        arow_d      = arow_q;
        if (row_me && row_activate_cmd) flag_d = 1'b0;
        if (row_me && (sleep_request_cmd || conditional_sleep_cmd)) flag_d = 1'b1;
        case (state_q)
            mps_pkg::S_DEEP_POWERDOWN, mps_pkg::S_LIGHT_SLEEP: begin
                if (exit_ok) state_d = exit_attention_active_q ? mps_pkg::S_ATTENTION : mps_pkg::S_STANDBY_IDLE;
            end
            mps_pkg::S_STANDBY_IDLE, mps_pkg::S_ATTENTION, mps_pkg::S_ATTENTION_RD,
            mps_pkg::S_ATTENTION_WR: begin
                if (pdn_go || sleep_go) begin
                    state_d     = pdn_go ? mps_pkg::S_DEEP_POWERDOWN : mps_pkg::S_LIGHT_SLEEP;
                    exit_attention_active_d = attention_active_grp && !row_relax_cmd;
                end else if (attention_active_grp && rel_any) begin
                    state_d = mps_pkg::S_STANDBY_IDLE;
                end else if (row_new) begin
                    if (!attention_active_grp) begin
                        state_d = mps_pkg::S_ATTENTION;
                        frm_d   = frm_ivl;
                    end
                    act_d   = row_activate_cmd || !attention_active_grp;
                    abank_d = row_bank;
                    arow_d  = row_addr;
                end else if (attention_active_grp && col_pkt_valid && ok_q) begin
                    if (col_write_cmd) state_d = mps_pkg::S_ATTENTION_WR;
                    else if (col_read_cmd) state_d = mps_pkg::S_ATTENTION_RD;
                end
            end
            default: state_d = mps_pkg::S_DEEP_POWERDOWN;
        endcase
        if (set_reset_cmd) begin
            state_d     = mps_pkg::S_DEEP_POWERDOWN;
            exit_attention_active_d = 1'b0;
        end
        ok_d = (frm_d == 4'h0) && ((state_d == mps_pkg::S_ATTENTION) ||
               (state_d == mps_pkg::S_ATTENTION_RD) || (state_d == mps_pkg::S_ATTENTION_WR));
    end
    // register the state group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= mps_pkg::S_DEEP_POWERDOWN;
            exit_attention_active_q <= 1'b0;
            flag_q      <= 1'b0;
            frm_q       <= 4'h0;
            ok_q        <= 1'b0;
            act_q       <= 1'b0;
            abank_q     <= 4'h0;
            arow_q      <= 9'h000;
            wake_q      <= mps_pkg::W_IDLE;
            wsio_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            exit_attention_active_q <= exit_attention_active_d;
            flag_q      <= flag_d;
            frm_q       <= frm_d;
            ok_q        <= ok_d;
            act_q       <= act_d;
            abank_q     <= abank_d;
            arow_q      <= arow_d;
            wake_q      <= wake_d;
            wsio_q      <= wsio_d;
        end
    end

    // ************************************************************
    // self-refresh and clock sync
    // ************************************************************
    logic        srf_q, srf_d;           // self-refresh running
    logic        sync_q, sync_d;         // clock sync block kept
    logic [11:0] rt_q, rt_d;             // interval timer
    logic        tick_q, tick_d;
    logic [3:0]  rb_q, rb_d;
    logic [8:0]  rr_q, rr_d;
    // walks every bank of every row on its own timer
    always_comb begin
        // powerdown, or sleep with refresh bit
        srf_d  = (state_d == mps_pkg::S_DEEP_POWERDOWN) || (state_d == mps_pkg::S_LIGHT_SLEEP && srf);
        sync_d = (state_d != mps_pkg::S_DEEP_POWERDOWN);
        rt_d   = rt_q;
        tick_d = 1'b0;
        rb_d   = rb_q;
        rr_d   = rr_q;
        if (!srf_q) begin
            rt_d = 12'h000;
        end else if (rt_q == REF_CYC - 12'h001) begin
            rt_d   = 12'h000;
            tick_d = 1'b1;
            rb_d   = rb_q + 4'h1;
            if (rb_q == 4'hF) rr_d = rr_q + 9'h001;
        end else begin
            rt_d = rt_q + 12'h001;
        end
    end
    // register refresh group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srf_q  <= 1'b1;
            sync_q <= 1'b0;
            rt_q   <= 12'h000;
            tick_q <= 1'b0;
            rb_q   <= 4'h0;
            rr_q   <= 9'h000;
        end else begin
            srf_q  <= srf_d;
            sync_q <= sync_d;
            rt_q   <= rt_d;
            tick_q <= tick_d;
            rb_q   <= rb_d;
            rr_q   <= rr_d;
        end
    end
    assign power_state       = state_q;
    assign col_frame_ok      = ok_q;
    assign clock_sync_keep   = sync_q;
    assign self_refresh_on   = srf_q;
    assign self_refresh_tick = tick_q;
    assign refresh_bank      = rb_q;
    assign refresh_row       = rr_q;
    assign bank_activate     = act_q;
    assign activate_bank     = abank_q;
    assign activate_row      = arow_q;

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_cond_no_flag;
        state_q == mps_pkg::S_STANDBY_IDLE && row_me && conditional_sleep_cmd && !flag_q &&
        !powerdown_request_cmd && !sleep_request_cmd && !set_reset_cmd;
    endsequence
    property p_cond_ignored;
        @(posedge pclk) disable iff (!presetn) s_cond_no_flag |=> state_q == mps_pkg::S_STANDBY_IDLE;
    endproperty
    a_cond_ignored: assert property (p_cond_ignored) else $error("conditional sleep taken without flag");
    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
            row_me && row_activate_cmd && !sleep_request_cmd && !conditional_sleep_cmd |=> !flag_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("activate did not clear sleep flag");
    property p_set_reset;
        @(posedge pclk) disable iff (!presetn)
            set_reset_cmd |=> state_q == mps_pkg::S_DEEP_POWERDOWN && !exit_attention_active_q ##1 self_refresh_on;
    endproperty
    a_set_reset: assert property (p_set_reset) else $error("set-reset did not reach powerdown");
    property p_row_enter;
        @(posedge pclk) disable iff (!presetn)
            state_q == mps_pkg::S_STANDBY_IDLE && row_new && !set_reset_cmd
            |=> state_q == mps_pkg::S_ATTENTION && bank_activate;
    endproperty
    a_row_enter: assert property (p_row_enter) else $error("row packet did not enter attention");
    property p_frame_wait;
        @(posedge pclk) disable iff (!presetn)
            state_q == mps_pkg::S_STANDBY_IDLE && row_new && !set_reset_cmd && frm_ivl != 4'h0
            |=> !col_frame_ok;
    endproperty
    a_frame_wait: assert property (p_frame_wait) else $error("columns framed too early");
    property p_write_sub;
        @(posedge pclk) disable iff (!presetn)
            attention_active_grp && col_pkt_valid && ok_q && col_write_cmd && !rel_any && !row_me && !set_reset_cmd
            |=> state_q == mps_pkg::S_ATTENTION_WR;
    endproperty
    a_write_sub: assert property (p_write_sub) else $error("write did not enter write substate");
    property p_relax;
        @(posedge pclk) disable iff (!presetn)
            attention_active_grp && rel_any && !sleep_go && !pdn_go && !set_reset_cmd
            |=> state_q == mps_pkg::S_STANDBY_IDLE;
    endproperty
    a_relax: assert property (p_relax) else $error("relax did not return to standby");
    property p_exit_target;
        @(posedge pclk) disable iff (!presetn)
            exit_ok && !set_reset_cmd |=> (state_q == mps_pkg::S_ATTENTION) == $past(exit_attention_active_q);
    endproperty
    a_exit_target: assert property (p_exit_target) else $error("wake exit went to wrong state");
    property p_pdn_refresh;
        @(posedge pclk) disable iff (!presetn)
            state_q == mps_pkg::S_DEEP_POWERDOWN |-> self_refresh_on && !clock_sync_keep;
    endproperty
    a_pdn_refresh: assert property (p_pdn_refresh) else $error("powerdown without self-refresh");
endmodule : mps_power_ctrl
`default_nettype wire

/* File: sim/mps_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// controller side of the serial wake pins
// ****
module mps_ctl_model (
    // clock used to pace the 120 ns serial clock
    input  wire logic pclk,
    // serial pins toward the device
    output logic       serial_clock,
    output logic       command_pin,
    output logic       serial_io_pin,
    output logic [5:0] data_byte_a_pins
);
    // pins start idle with the serial clock high; it toggles only inside wake
    initial begin
        serial_clock = 1'b1;
        command_pin = 1'b0;
        serial_io_pin = 1'b0;
        data_byte_a_pins = 6'h3F;
    end
    // third of a serial period
    task q;
        repeat (10) @(posedge pclk);
    endtask : q
    // wake frame, k exit kind, a address, d slot
    task wake(input logic k, input logic [5:0] a, input logic d);
        command_pin <= 1'b0;
        serial_io_pin <= k;
        data_byte_a_pins <= d ? ~a : a;
        q;
        serial_clock <= 1'b0;
        q;
        command_pin <= 1'b1;
        q;
        serial_clock <= 1'b1;
        q;
        data_byte_a_pins <= d ? a : ~a;
        serial_clock <= 1'b0;
        q;
        q;
        serial_clock <= 1'b1;
        q;
        // address hold over: show the inverse
        data_byte_a_pins <= ~a;
        command_pin <= 1'b0;
        serial_io_pin <= ~k;
        // wake well inside the limit, rows quiet meanwhile
        q;
    endtask : wake
endmodule : mps_ctl_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// power state bench
// ****
`include "mps_consts.svh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ba, cf;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        row_pkt_valid, row_pkt_broadcast, row_pkt_hit, row_activate_cmd, sleep_request_cmd;
    logic        conditional_sleep_cmd, powerdown_request_cmd, row_relax_cmd, col_pkt_valid, col_read_cmd;
    logic        col_write_cmd, relax_cmd, set_reset_cmd, serial_clock, command_pin, serial_io_pin;
    logic [5:0]  data_byte_a_pins, power_state;
    logic        col_frame_ok, clock_sync_keep, self_refresh_on, self_refresh_tick, bank_activate;
    logic [3:0]  row_bank, refresh_bank, activate_bank;
    logic [8:0]  row_addr, refresh_row, activate_row;
    int          n_fail, n_checks, cyc;
    // design and controller model
    mps_power_ctrl dut (.*);
    mps_ctl_model  ctl (.*);
    // free running clock
    always #2 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            end_sim;
        end
    end
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", n, e, g);
            n_fail++;
        end
    endtask : chk
    // one apb transfer, waits for pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let an edge pass before the next setup
        @(posedge pclk);
    endtask : apb
    // row packet, f = {broadcast, activate, sleep, cond sleep, powerdown, relax}
    task row(input logic [5:0] f);
        {row_pkt_broadcast, row_activate_cmd, sleep_request_cmd, conditional_sleep_cmd,
         powerdown_request_cmd, row_relax_cmd} <= f;
        row_pkt_valid <= 1'b1;
        @(posedge pclk);
        row_pkt_valid <= 1'b0;
        @(posedge pclk);
        // strobe and framing as they stood after the taking edge
        ba = bank_activate;
        cf = col_frame_ok;
    endtask : row
    // column packet, f = {read, write, relax}
    task col(input logic [2:0] f);
        {col_read_cmd, col_write_cmd, relax_cmd} <= f;
        col_pkt_valid <= 1'b1;
        @(posedge pclk);
        col_pkt_valid <= 1'b0;
        @(posedge pclk);
    endtask : col
    // bounded wait for a power state
    task ws(input logic [5:0] e);
        for (int i = 0; i < 200 && power_state !== e; i++) @(posedge pclk);
        chk("power_state", 32'(e), 32'(power_state));
    endtask : ws
    // activate from standby, then wait for column framing
    task act;
        row(6'h10);
        ws(6'h08);
        chk("bank_activate", 32'h1, 32'(ba));
        chk("activate_row", 32'h15A, 32'(activate_row));
        chk("activate_bank", 32'h9, 32'(activate_bank));
        chk("col_frame_early", 32'h0, 32'(cf));
        for (int i = 0; i < 8 && col_frame_ok !== 1'b1; i++) @(posedge pclk);
        chk("col_frame_ok", 32'h1, 32'(col_frame_ok));
    endtask : act
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, row_pkt_valid, row_pkt_broadcast, row_activate_cmd,
         sleep_request_cmd, conditional_sleep_cmd, powerdown_request_cmd, row_relax_cmd, col_pkt_valid,
         col_read_cmd, col_write_cmd, relax_cmd, set_reset_cmd} = '0;
        row_pkt_hit = 1'b1;
        row_bank = 4'h9;
        row_addr = 9'h15A;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("power_state", 32'h01, 32'(power_state));
        chk("self_refresh_on", 32'h1, 32'(self_refresh_on));
        for (int i = 0; i < `MPS_REFRESH_CYCLES + 4 && self_refresh_tick !== 1'b1; i++) @(posedge pclk);
        chk("self_refresh_tick", 32'h1, 32'(self_refresh_tick));
        chk("refresh_bank", 32'h1, 32'(refresh_bank));
        chk("refresh_row", 32'h0, 32'(refresh_row));
        apb(1'b0, 12'h004, 32'h0);
        chk("status", 32'h41, rd);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        apb(1'b1, 12'h000, 32'h3050);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h3050, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        $display("test registers done");
        ctl.wake(1'b0, 6'h05, 1'b0);
        chk("power_state", 32'h01, 32'(power_state));
        ctl.wake(1'b1, 6'h06, 1'b0);
        chk("power_state", 32'h01, 32'(power_state));
        ctl.wake(1'b1, 6'h05, 1'b0);
        ws(6'h04);
        row(6'h30);
        ws(6'h04);
        row(6'h04);
        ws(6'h04);
        row(6'h08);
        ws(6'h02);
        chk("self_refresh_on", 32'h0, 32'(self_refresh_on));
        chk("clock_sync_keep", 32'h1, 32'(clock_sync_keep));
        ctl.wake(1'b0, 6'h05, 1'b0);
        ws(6'h04);
        row(6'h04);
        ws(6'h02);
        ctl.wake(1'b0, 6'h05, 1'b0);
        ws(6'h04);
        $display("test sleep done");
        act;
        row(6'h01);
        ws(6'h04);
        row(6'h04);
        ws(6'h04);
        act;
        col(3'b010);
        ws(6'h20);
        col(3'b100);
        ws(6'h10);
        col(3'b001);
        ws(6'h04);
        $display("test attention done");
        act;
        apb(1'b1, 12'h000, 32'h3056);
        row(6'h08);
        ws(6'h02);
        chk("self_refresh_on", 32'h1, 32'(self_refresh_on));
        apb(1'b0, 12'h004, 32'h0);
        chk("status", 32'hC2, rd);
        ctl.wake(1'b0, 6'h05, 1'b1);
        ws(6'h08);
        apb(1'b1, 12'h000, 32'h3053);
        row(6'h03);
        ws(6'h01);
        chk("self_refresh_on", 32'h1, 32'(self_refresh_on));
        chk("clock_sync_keep", 32'h0, 32'(clock_sync_keep));
        ctl.wake(1'b1, 6'h2A, 1'b1);
        ws(6'h04);
        set_reset_cmd <= 1'b1;
        @(posedge pclk);
        set_reset_cmd <= 1'b0;
        ws(6'h01);
        ctl.wake(1'b1, 6'h00, 1'b0);
        ws(6'h04);
        $display("test wake done");
        end_sim;
    end
endmodule : tb_top
`default_nettype wire
